// ==== design/fdhri_crc16.sv ====
// serial sixteen-bit check code generator and checker
module fdhri_crc16
   import fdhri_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic preset, // start of address mark
   input wire logic shift, // one bit enters
   input wire logic bit_in,
   output logic [15:0] crc,
   output logic crc_zero // whole field incl. check bytes passed clean
);
   // ==========================================
   // register
   logic [15:0] crc_reg;
   logic [15:0] crc_next;
   logic fb;

   // feedback of msb against incoming bit
   assign fb = crc_reg[15] ^ bit_in;
   assign crc_next = {crc_reg[14:0], 1'b0} ^ (fb ? FDHRI_CRC_POLY : 16'h0000);

   // preset wins so a new mark restarts cleanly
   always_ff @(posedge clk) begin
      if (rst || preset) begin
         crc_reg <= FDHRI_CRC_PRESET;
      end else if (shift) begin
         crc_reg <= crc_next;
      end
   end

   assign crc = crc_reg;
   assign crc_zero = (crc_reg == 16'h0000);
endmodule // fdhri_crc16

// ==== design/fdhri_pkg.sv ====
// constants, types and helpers for the floppy host register interface
package fdhri_pkg;
   // ==========================================
   // register select codes
   localparam logic [1:0] FDHRI_SEL_STATUS = 2'h0; // read status, write command
   localparam logic [1:0] FDHRI_SEL_TRACK = 2'h1;
   localparam logic [1:0] FDHRI_SEL_SECTOR = 2'h2;
   localparam logic [1:0] FDHRI_SEL_DATA = 2'h3;
   // ==========================================
   // reset values
   localparam logic [7:0] FDHRI_CMD_RST = 8'h00;
   localparam logic [7:0] FDHRI_TRACK_RST = 8'h00;
   localparam logic [7:0] FDHRI_SECTOR_RST = 8'h00;
   localparam logic [7:0] FDHRI_DATA_RST = 8'h00;
   localparam logic [7:0] FDHRI_ZERO_BYTE = 8'h00; // sent when host is late
   // ==========================================
   // status word bit positions
   localparam int FDHRI_ST_BUSY = 0;
   localparam int FDHRI_ST_REQ = 1;
   localparam int FDHRI_ST_LOST = 2;
   // ==========================================
   // check code
   localparam logic [15:0] FDHRI_CRC_POLY = 16'h1021; // x16 + x12 + x5 + 1
   localparam logic [15:0] FDHRI_CRC_PRESET = 16'hFFFF;
   // ==========================================
   // timing: bit cell lengths per density
   localparam int FDHRI_CLK_PERIOD_NS = 4;
   localparam int FDHRI_FM_CELL_NS = 4000; // plain default, single density
   localparam int FDHRI_MFM_CELL_NS = 2000; // plain default, double density
   // longest time rounds down, never below one cycle
   function automatic int fdhri_cycles(input int ns);
      int c;
      c = ns / FDHRI_CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction
   localparam int FDHRI_FM_CELL_CYC = fdhri_cycles(FDHRI_FM_CELL_NS);
   localparam int FDHRI_MFM_CELL_CYC = fdhri_cycles(FDHRI_MFM_CELL_NS);
   localparam int FDHRI_BITS_PER_BYTE = 8;
   // ==========================================
   // one host access as seen after decode
   typedef struct packed {
      logic rd; // chip select and read strobe both low
      logic wr; // chip select and write strobe both low
      logic [1:0] sel;
   } fdhri_acc_t;
endpackage : fdhri_pkg

// ==== design/fdhri_shifter.sv ====
// eight-bit serial data shift register for disk reads and writes
module fdhri_shifter
   import fdhri_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic bit_tick, // one pulse per bit cell
   input wire logic read_mode,
   input wire logic write_mode,
   input wire logic bit_in, // raw read bit
   input wire logic [7:0] load_byte, // byte for the write side
   output logic need_byte, // write side takes load_byte now
   output logic byte_ready, // read side byte complete (pulse)
   output logic [7:0] byte_out,
   output logic bit_out // serial write bit
);
   // ==========================================
   // state
   logic [7:0] shift_reg;
   logic [2:0] cnt_reg;
   logic last_bit;

   assign last_bit = (cnt_reg == 3'(FDHRI_BITS_PER_BYTE - 1));
   assign need_byte = write_mode && bit_tick && (cnt_reg == 3'h0);
   assign byte_out = shift_reg;
   assign bit_out = shift_reg[7];

   // assemble msb first; write loads at a byte boundary
   always_ff @(posedge clk) begin
      if (rst || !(read_mode || write_mode)) begin
         shift_reg <= 8'h00;
         cnt_reg <= 3'h0;
         byte_ready <= 1'b0;
      end else begin
         byte_ready <= read_mode && bit_tick && last_bit;
         if (bit_tick) begin
            cnt_reg <= cnt_reg + 3'h1;
            if (need_byte) begin
               shift_reg <= load_byte;
            end else if (read_mode) begin
               shift_reg <= {shift_reg[6:0], bit_in};
            end else begin
               shift_reg <= {shift_reg[6:0], 1'b0};
            end
         end
      end
   end
endmodule // fdhri_shifter

// ==== design/fdhri_top.sv ====
// host register section of the floppy formatter: decode, data path, flags
module fdhri_top
   import fdhri_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST,
   // host side
   input wire logic CS_N,
   input wire logic HOST_FETCH_STROBE_N,
   input wire logic HOST_STORE_STROBE_N,
   input wire logic SELECT_HI,
   input wire logic SELECT_LO,
   input wire logic [7:0] HOST_BUS_LINES_I,
   output logic [7:0] HOST_BUS_LINES_O,
   output logic HOST_BUS_LINES_OE_N,
   output logic BYTE_TRANSFER_REQUEST,
   output logic COMPLETION_IRQ,
   // drive side
   input wire logic DENSITY_SELECT_N,
   input wire logic RAW_READ_BIT,
   output logic WRITE_DATA_BIT,
   output logic DOUBLE_DENSITY,
   // command sequencer side
   input wire logic SEQ_READ_MODE,
   input wire logic SEQ_WRITE_MODE,
   input wire logic SEQ_CMD_DONE,
   input wire logic SEQ_FORCE_COND,
   input wire logic SEQ_STEP_IN,
   input wire logic SEQ_STEP_OUT,
   input wire logic SEQ_ID_CHECK,
   input wire logic [7:0] SEQ_ID_TRACK,
   input wire logic [7:0] SEQ_ID_SECTOR,
   input wire logic SEQ_CRC_PRESET,
   input wire logic SEQ_CRC_ENABLE,
   input wire logic [4:0] SEQ_STATUS_HI,
   output logic [7:0] CMD_WORD,
   output logic CMD_STROBE,
   output logic [7:0] SEEK_TARGET,
   output logic TRACK_MATCH,
   output logic SECTOR_MATCH,
   output logic CRC_OK
);
   // ==========================================
   // host access decode
   fdhri_acc_t acc; // current access
   logic rd_d_reg; // read seen last cycle
   logic wr_d_reg; // write seen last cycle
   logic rd_start; // first cycle of a read
   logic wr_start; // first cycle of a write
   logic [1:0] sel;

   assign acc.rd = !CS_N && !HOST_FETCH_STROBE_N;
   assign acc.wr = !CS_N && !HOST_STORE_STROBE_N;
   assign acc.sel = {SELECT_HI, SELECT_LO};
   assign sel = acc.sel;
   // act on strobe leading edge so a long strobe counts once
   assign rd_start = acc.rd && !rd_d_reg;
   assign wr_start = acc.wr && !wr_d_reg;

   // select-specific strobes
   logic rd_status;
   logic rd_data;
   logic wr_cmd;
   logic wr_track;
   logic wr_sector;
   logic wr_data;
   assign rd_status = rd_start && (sel == FDHRI_SEL_STATUS);
   assign rd_data = rd_start && (sel == FDHRI_SEL_DATA);
   assign wr_cmd = wr_start && (sel == FDHRI_SEL_STATUS);
   assign wr_track = wr_start && (sel == FDHRI_SEL_TRACK);
   assign wr_sector = wr_start && (sel == FDHRI_SEL_SECTOR);
   assign wr_data = wr_start && (sel == FDHRI_SEL_DATA);

   // strobe edge history
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         rd_d_reg <= 1'b0;
         wr_d_reg <= 1'b0;
      end else begin
         rd_d_reg <= acc.rd;
         wr_d_reg <= acc.wr;
      end
   end

   // ==========================================
   // density and bit cell divider
   logic mfm_reg; // double density selected
   logic [9:0] cell_cnt_reg;
   logic bit_tick;
   logic [9:0] cell_len;
   logic xfer_mode;

   // double density when the select input is low
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         mfm_reg <= 1'b0;
      end else begin
         mfm_reg <= !DENSITY_SELECT_N;
      end
   end

   assign cell_len = mfm_reg ? 10'(FDHRI_MFM_CELL_CYC - 1) : 10'(FDHRI_FM_CELL_CYC - 1);
   assign bit_tick = xfer_mode && (cell_cnt_reg == cell_len);
   assign xfer_mode = SEQ_READ_MODE || SEQ_WRITE_MODE;

   // free divider, held at zero outside transfers
   always_ff @(posedge REF_CLK) begin
      if (RST || !xfer_mode || bit_tick) begin
         cell_cnt_reg <= 10'h000;
      end else begin
         cell_cnt_reg <= cell_cnt_reg + 10'h001;
      end
   end

   // ==========================================
   // registers seen by the host
   logic [7:0] cmd_reg;
   logic [7:0] track_reg;
   logic [7:0] sector_reg;
   logic [7:0] data_reg;
   logic busy_reg;
   logic req_reg;
   logic lost_reg;
   logic irq_reg;
   logic cmd_stb_reg;
   logic [7:0] status_word;

   // ==========================================
   // serial data path
   logic need_byte;
   logic byte_ready;
   logic [7:0] sh_byte;
   logic sh_bit;
   logic [7:0] load_byte;
   logic late_write; // host has not refilled in time

   assign late_write = req_reg;
   assign load_byte = late_write ? FDHRI_ZERO_BYTE : data_reg;

   fdhri_shifter u_shift (
      .clk(REF_CLK),
      .rst(RST),
      .bit_tick(bit_tick),
      .read_mode(SEQ_READ_MODE),
      .write_mode(SEQ_WRITE_MODE),
      .bit_in(RAW_READ_BIT),
      .load_byte(load_byte),
      .need_byte(need_byte),
      .byte_ready(byte_ready),
      .byte_out(sh_byte),
      .bit_out(sh_bit)
   );

   // check code sees the bit stream in either direction
   logic crc_bit;
   // the full check code stays inside; only its zero test leaves
   logic crc_zero;
   assign crc_bit = SEQ_WRITE_MODE ? sh_bit : RAW_READ_BIT;

   fdhri_crc16 u_crc (
      .clk(REF_CLK),
      .rst(RST),
      .preset(SEQ_CRC_PRESET),
      .shift(SEQ_CRC_ENABLE && bit_tick),
      .bit_in(crc_bit),
      .crc(),
      .crc_zero(crc_zero)
   );

   // ==========================================
   // command, track and sector registers
   // busy writes are the host's problem; the device still takes them
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         cmd_reg <= FDHRI_CMD_RST;
         cmd_stb_reg <= 1'b0;
      end else begin
         cmd_stb_reg <= wr_cmd;
         if (wr_cmd) begin
            cmd_reg <= HOST_BUS_LINES_I;
         end
      end
   end

   // step updates win over a host write in the same cycle
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         track_reg <= FDHRI_TRACK_RST;
      end else if (SEQ_STEP_IN) begin
         track_reg <= track_reg + 8'h01;
      end else if (SEQ_STEP_OUT) begin
         track_reg <= track_reg - 8'h01;
      end else if (wr_track) begin
         track_reg <= HOST_BUS_LINES_I;
      end
   end

   // sector register
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         sector_reg <= FDHRI_SECTOR_RST;
      end else if (wr_sector) begin
         sector_reg <= HOST_BUS_LINES_I;
      end
   end

   // holding register: disk byte in on reads, host byte in otherwise
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         data_reg <= FDHRI_DATA_RST;
      end else if (byte_ready) begin
         data_reg <= sh_byte;
      end else if (wr_data) begin
         data_reg <= HOST_BUS_LINES_I;
      end
   end

   // ==========================================
   // transfer request, lost data, busy, interrupt
   logic req_set;
   logic req_clr;
   logic lost_set;
   logic irq_set;
   logic irq_clr;

   assign req_set = byte_ready || need_byte;
   assign req_clr = (SEQ_READ_MODE && rd_data) || (SEQ_WRITE_MODE && wr_data);
   assign lost_set = (byte_ready && req_reg) || (need_byte && late_write);
   assign irq_set = SEQ_CMD_DONE || SEQ_FORCE_COND;
   assign irq_clr = rd_status || wr_cmd;

   // request flag: a new byte event beats a host clear
   always_ff @(posedge REF_CLK) begin
      if (RST || !xfer_mode) begin
         req_reg <= 1'b0;
      end else if (req_set) begin
         req_reg <= 1'b1;
      end else if (req_clr) begin
         req_reg <= 1'b0;
      end
   end

   // lost data lives until the next command
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         lost_reg <= 1'b0;
      end else if (lost_set) begin
         lost_reg <= 1'b1;
      end else if (wr_cmd) begin
         lost_reg <= 1'b0;
      end
   end

   // busy from command taken to completion
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         busy_reg <= 1'b0;
      end else if (SEQ_CMD_DONE) begin
         busy_reg <= 1'b0;
      end else if (wr_cmd) begin
         busy_reg <= 1'b1;
      end
   end

   // interrupt request: set beats clear
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         irq_reg <= 1'b0;
      end else if (irq_set) begin
         irq_reg <= 1'b1;
      end else if (irq_clr) begin
         irq_reg <= 1'b0;
      end
   end

   // ==========================================
   // status word and host read path
   logic [7:0] rd_mux;
   assign status_word = {SEQ_STATUS_HI, lost_reg, req_reg && xfer_mode, busy_reg};
   // the command word is never readable
   assign rd_mux = (sel == FDHRI_SEL_STATUS) ? status_word :
                   (sel == FDHRI_SEL_TRACK) ? track_reg :
                   (sel == FDHRI_SEL_SECTOR) ? sector_reg : data_reg;

   // bus drive is registered: one cycle behind the strobes
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         HOST_BUS_LINES_O <= 8'h00;
         HOST_BUS_LINES_OE_N <= 1'b1;
      end else begin
         HOST_BUS_LINES_O <= acc.rd ? rd_mux : 8'h00;
         HOST_BUS_LINES_OE_N <= !acc.rd;
      end
   end

   // ==========================================
   // id field compare and remaining outputs
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         TRACK_MATCH <= 1'b0;
         SECTOR_MATCH <= 1'b0;
      end else if (SEQ_ID_CHECK) begin
         TRACK_MATCH <= (SEQ_ID_TRACK == track_reg);
         SECTOR_MATCH <= (SEQ_ID_SECTOR == sector_reg);
      end
   end

   // all other outputs straight from flops
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         WRITE_DATA_BIT <= 1'b0;
         DOUBLE_DENSITY <= 1'b0;
         SEEK_TARGET <= FDHRI_DATA_RST;
         CRC_OK <= 1'b0;
      end else begin
         WRITE_DATA_BIT <= SEQ_WRITE_MODE && sh_bit;
         DOUBLE_DENSITY <= mfm_reg;
         SEEK_TARGET <= data_reg;
         CRC_OK <= crc_zero;
      end
   end

   // signal-level outputs: single clock for everything
   assign BYTE_TRANSFER_REQUEST = req_reg;
   assign COMPLETION_IRQ = irq_reg;
   assign CMD_WORD = cmd_reg;
   assign CMD_STROBE = cmd_stb_reg;

   // ==========================================
   // checks
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);

   chk_bus_drive: assert property (acc.rd |=> !HOST_BUS_LINES_OE_N)
      else $error("bus not driven during read");
   chk_bus_quiet: assert property (!acc.rd |=> HOST_BUS_LINES_OE_N)
      else $error("bus driven outside read");
   chk_status_sel: assert property (acc.rd && sel == FDHRI_SEL_STATUS |=> HOST_BUS_LINES_O == $past(status_word))
      else $error("status select returned wrong word");
   chk_track_step: assert property (SEQ_STEP_IN |=> track_reg == $past(track_reg) + 8'h01)
      else $error("track did not step in");
   chk_req_read: assert property (SEQ_READ_MODE && byte_ready |=> req_reg && data_reg == $past(sh_byte))
      else $error("read byte did not raise request");
   chk_lost_read: assert property (byte_ready && req_reg |=> lost_reg)
      else $error("overrun not flagged");
   chk_zero_write: assert property (need_byte && req_reg |-> load_byte == 8'h00 ##1 lost_reg)
      else $error("late write not zeroed");
   chk_irq_done: assert property (SEQ_CMD_DONE |=> COMPLETION_IRQ && !busy_reg)
      else $error("completion did not raise irq");
   chk_irq_clear: assert property (rd_status && !irq_set |=> !COMPLETION_IRQ)
      else $error("status read did not clear irq");
   chk_busy_cmd: assert property (wr_cmd && !SEQ_CMD_DONE |=> busy_reg && CMD_STROBE)
      else $error("command did not set busy");

   cov_read_byte: cover property (byte_ready ##[1:8] rd_data);
   cov_write_late: cover property (need_byte && req_reg);
   cov_force_irq: cover property (SEQ_FORCE_COND ##1 COMPLETION_IRQ);
endmodule // fdhri_top

// ==== sim/fdhri_host_model.sv ====
// host processor model for the byte-wide register port of the floppy section
module fdhri_host_model
   import fdhri_pkg::*;
(
   input wire logic clk,
   output logic cs_n,
   output logic fetch_n,
   output logic store_n,
   output logic sel_hi,
   output logic sel_lo,
   output logic [7:0] bus_i,
   input wire logic [7:0] bus_o,
   input wire logic bus_oe_n
);
   timeunit 1ns;
   timeprecision 100ps;
   logic drv; // host drives the lines
   logic [7:0] dout; // byte the host drives
   logic [7:0] last; // level seen last cycle
   // ==========================================
   // shared wire resolution
   // nobody driving: lines flip every cycle so a stale byte never passes for a read
   assign bus_i = !bus_oe_n ? bus_o : (drv ? dout : ~last);
   always @(posedge clk) begin
      last <= bus_i;
   end
   // idle host at time zero
   initial begin
      cs_n = 1'b1;
      fetch_n = 1'b1;
      store_n = 1'b1;
      {sel_hi, sel_lo} = 2'b00;
      drv = 1'b0;
      dout = 8'h00;
   end
   // ==========================================
   // one write: set after a falling edge, held over the taking edge
   // callers keep track and sector writes away from busy spells
   task automatic wr(input logic [1:0] sel, input logic [7:0] d);
      @(negedge clk);
      {sel_hi, sel_lo} = sel;
      dout = d;
      drv = 1'b1;
      cs_n = 1'b0;
      store_n = 1'b0;
      @(negedge clk);
      cs_n = 1'b1;
      store_n = 1'b1;
      drv = 1'b0;
      @(negedge clk); // strobes high a full cycle between accesses
   endtask
   // one read: byte taken from the wire once the registered answer is up
   task automatic rd(input logic [1:0] sel, output logic [7:0] d);
      @(negedge clk);
      {sel_hi, sel_lo} = sel;
      cs_n = 1'b0;
      fetch_n = 1'b0;
      @(negedge clk); // taking edge passed
      @(negedge clk); // answer now on the lines
      d = bus_i;
      cs_n = 1'b1;
      fetch_n = 1'b1;
      @(negedge clk);
   endtask
endmodule // fdhri_host_model

// ==== sim/floppy_host_register_interface_bench.sv ====
// self-checking bench for the floppy host register section
module floppy_host_register_interface_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import fdhri_pkg::*;
   localparam int LIMIT = 60000; // cycle ceiling, run needs about 31000
   logic ref_clk, rst, cs_n, fetch_n, store_n, sel_hi, sel_lo, oe_n, req, irq;
   logic dsel_n, raw, wbit, dd, rmode, wmode, cmd_stb, t_match, s_match, crc_ok, crc_en;
   logic [7:0] bus_i, bus_o, id_trk, id_sec, cmd_word, seek_t;
   logic [4:0] st_hi; // upper status bits from the sequencer
   logic [5:0] pv; // pulses: done, force, in, out, id check, crc preset
   logic [7:0] pat [3] = '{8'h12, 8'h05, 8'hc3}; // track, sector, data
   logic [23:0] frame; // one byte and its check bytes, msb first
   int mismatches, n_tests, cyc, c, n_cmd;
   // ==========================================
   // clock and timeout
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   initial begin
      cyc = 0;
      forever begin
         @(posedge ref_clk);
         cyc++;
         if (cyc == LIMIT) begin
            mismatches++;
            give_verdict();
         end
      end
   end
   // ==========================================
   // design and host
   fdhri_top dut_u (.REF_CLK(ref_clk), .RST(rst), .CS_N(cs_n), .HOST_FETCH_STROBE_N(fetch_n),
      .HOST_STORE_STROBE_N(store_n), .SELECT_HI(sel_hi), .SELECT_LO(sel_lo), .HOST_BUS_LINES_I(bus_i),
      .HOST_BUS_LINES_O(bus_o), .HOST_BUS_LINES_OE_N(oe_n), .BYTE_TRANSFER_REQUEST(req),
      .COMPLETION_IRQ(irq), .DENSITY_SELECT_N(dsel_n), .RAW_READ_BIT(raw), .WRITE_DATA_BIT(wbit),
      .DOUBLE_DENSITY(dd), .SEQ_READ_MODE(rmode), .SEQ_WRITE_MODE(wmode), .SEQ_CMD_DONE(pv[0]),
      .SEQ_FORCE_COND(pv[1]), .SEQ_STEP_IN(pv[2]), .SEQ_STEP_OUT(pv[3]), .SEQ_ID_CHECK(pv[4]),
      .SEQ_ID_TRACK(id_trk), .SEQ_ID_SECTOR(id_sec), .SEQ_CRC_PRESET(pv[5]), .SEQ_CRC_ENABLE(crc_en),
      .SEQ_STATUS_HI(st_hi), .CMD_WORD(cmd_word), .CMD_STROBE(cmd_stb), .SEEK_TARGET(seek_t),
      .TRACK_MATCH(t_match), .SECTOR_MATCH(s_match), .CRC_OK(crc_ok));
   fdhri_host_model u_host (.clk(ref_clk), .cs_n(cs_n), .fetch_n(fetch_n), .store_n(store_n),
      .sel_hi(sel_hi), .sel_lo(sel_lo), .bus_i(bus_i), .bus_o(bus_o), .bus_oe_n(oe_n));
   // ==========================================
   // helpers
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdchk(input logic [1:0] sel, input logic [7:0] exp);
      logic [7:0] v;
      u_host.rd(sel, v);
      chk({8'h00, v}, {8'h00, exp});
   endtask
   // one-cycle pulse, then a spare cycle so registered effects land
   task automatic pulse(input int b);
      @(negedge ref_clk);
      pv[b] = 1'b1;
      @(negedge ref_clk);
      pv[b] = 1'b0;
      @(negedge ref_clk);
   endtask
   // bounded wait for the transfer request
   task automatic wait_req(input int lim);
      int i;
      i = 0;
      while (req !== 1'b1 && i < lim) begin
         @(negedge ref_clk);
         i++;
      end
   endtask
   task automatic count_high(input int n, output int k);
      k = 0;
      repeat (n) begin
         @(negedge ref_clk);
         if (wbit === 1'b1) k++;
      end
   endtask
   function automatic logic [7:0] sw(input logic b, input logic r, input logic l);
      return {st_hi, l, r, b}; // busy bit 0, request bit 1, lost bit 2
   endfunction
   // reference check code, msb first, preset to ones
   function automatic logic [15:0] crc_ref(input logic [7:0] m);
      logic [15:0] r;
      r = FDHRI_CRC_PRESET;
      for (int i = 7; i >= 0; i--) begin
         r = {r[14:0], 1'b0} ^ ((r[15] ^ m[i]) ? FDHRI_CRC_POLY : 16'h0000);
      end
      return r;
   endfunction
   // every command write must hand one strobe to the sequencer
   always @(negedge ref_clk) begin
      if (cmd_stb === 1'b1) n_cmd++;
   end
   task automatic note(input string s);
      $display("test %s done", s);
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ==========================================
   // main sequence
   initial begin
      rst = 1'b1;
      dsel_n = 1'b0; // double density keeps bit cells short
      crc_en = 1'b0;
      raw = 1'b0;
      rmode = 1'b0;
      wmode = 1'b0;
      pv = 6'h00;
      id_trk = 8'h00;
      id_sec = 8'h00;
      st_hi = 5'h15;
      repeat (12) @(negedge ref_clk);
      rst = 1'b0;
      // reset values
      for (int i = 1; i < 4; i++) rdchk(2'(i), 8'h00);
      rdchk(FDHRI_SEL_STATUS, sw(0, 0, 0));
      @(negedge ref_clk);
      chk({oe_n, req, irq}, 3'b100);
      note("reset");
      // track, sector and data registers
      for (int i = 1; i < 4; i++) u_host.wr(2'(i), pat[i-1]);
      for (int i = 1; i < 4; i++) rdchk(2'(i), pat[i-1]);
      chk(seek_t, 8'hc3);
      pulse(2);
      rdchk(FDHRI_SEL_TRACK, 8'h13);
      pulse(3);
      pulse(3);
      rdchk(FDHRI_SEL_TRACK, 8'h11);
      id_trk = 8'h11;
      id_sec = 8'h05;
      pulse(4);
      chk({t_match, s_match}, 2'b11);
      id_sec = 8'h06;
      pulse(4);
      chk({t_match, s_match}, 2'b10);
      note("registers");
      // commands, busy and completion interrupt
      u_host.wr(FDHRI_SEL_STATUS, 8'h1c);
      chk(cmd_word, 8'h1c);
      rdchk(FDHRI_SEL_STATUS, sw(1, 0, 0));
      pulse(0);
      chk(irq, 1'b1);
      rdchk(FDHRI_SEL_STATUS, sw(0, 0, 0));
      chk(irq, 1'b0);
      u_host.wr(FDHRI_SEL_STATUS, 8'h18);
      u_host.wr(FDHRI_SEL_STATUS, 8'hd0);
      pulse(1);
      chk(irq, 1'b1);
      pulse(0);
      u_host.wr(FDHRI_SEL_STATUS, 8'h1c);
      chk(irq, 1'b0);
      pulse(0);
      rdchk(FDHRI_SEL_STATUS, sw(0, 0, 0));
      note("commands");
      // density input and check code preset
      dsel_n = 1'b1;
      repeat (2) @(negedge ref_clk);
      chk(dd, 1'b0);
      dsel_n = 1'b0;
      repeat (2) @(negedge ref_clk);
      chk(dd, 1'b1);
      pulse(5);
      chk(crc_ok, 1'b0);
      note("density");
      // disk read: ones byte, then zero bytes left unread
      raw = 1'b1;
      rmode = 1'b1;
      wait_req(5000);
      raw = 1'b0;
      rdchk(FDHRI_SEL_STATUS, sw(0, 1, 0));
      rdchk(FDHRI_SEL_DATA, 8'hff);
      chk(req, 1'b0);
      wait_req(5000);
      repeat (4100) @(negedge ref_clk); // one more byte of eight cells
      rdchk(FDHRI_SEL_STATUS, sw(0, 1, 1));
      rdchk(FDHRI_SEL_DATA, 8'h00);
      rmode = 1'b0;
      u_host.wr(FDHRI_SEL_STATUS, 8'h80);
      pulse(0);
      rdchk(FDHRI_SEL_STATUS, sw(0, 0, 0));
      note("disk read");
      // disk write: ones byte, then the host stays late
      u_host.wr(FDHRI_SEL_DATA, 8'hff);
      wmode = 1'b1;
      wait_req(1100);
      chk(req, 1'b1);
      repeat (4) @(negedge ref_clk);
      count_high(3000, c);
      chk(16'(c), 16'd3000);
      repeat (1500) @(negedge ref_clk);
      count_high(2000, c);
      chk(16'(c), 16'd0);
      rdchk(FDHRI_SEL_STATUS, sw(0, 1, 1));
      u_host.wr(FDHRI_SEL_DATA, 8'h55);
      chk(req, 1'b0);
      wmode = 1'b0;
      repeat (3) @(negedge ref_clk);
      chk({wbit, req}, 2'b00);
      note("disk write");
      // check code over one read byte followed by its own check bytes
      pulse(5);
      frame = {8'h96, crc_ref(8'h96)};
      crc_en = 1'b1;
      rmode = 1'b1;
      for (int i = 23; i >= 0; i--) begin
         raw = frame[i];
         repeat (FDHRI_MFM_CELL_CYC) @(negedge ref_clk);
      end
      repeat (2) @(negedge ref_clk);
      chk(crc_ok, 1'b1);
      rmode = 1'b0;
      crc_en = 1'b0;
      raw = 1'b0;
      pulse(5);
      chk(crc_ok, 1'b0);
      chk(16'(n_cmd), 16'd5);
      note("check code");
      give_verdict();
   end
endmodule // floppy_host_register_interface_bench
